/* bus_cycle_timeout_monitor.sv */
/*
 * bus cycle timeout monitor: processor bus and local peripheral bus timers
 * that end stalled cycles with a transfer error acknowledge or a peripheral bus error.
 * each bus has its own cycle timer; a fired timer is held off until the
 * stalled tenure ends, so one stall gives one error pulse.
 * the error outputs are one-cycle pulses with their enables high alongside.
 * assumes all bus strobes are active low and synchronous to core_clk_i.
 * assumes the limit inputs are held steady while a cycle is timed.
 */
// Contract
// - the processor bus timer counts only when enabled, from data bus busy.
// - an unterminated processor cycle past the limit gets a transfer error.
// - the processor bus timer is idle for cycles sent to the peripheral bus.
// - an enabled peripheral bus timer ends overlong accesses with an error.
// - the peripheral limit is 8 us, 64 us, 256 us or infinite.
// - the peripheral bus timer does not count during VMEbus bound cycles.
// - undecoded accesses get no ack and are ended by the enabled timeout.
`timescale 1ns/1ps
`include "bus_timeout_regs.svh"

module bus_cycle_timeout_monitor
#(
    parameter bus_timeout_pkg::cnt_t LIM_8US = 16'(`LPB_LIM_8US_NS
        / `CLK_PERIOD_NS),
    parameter bus_timeout_pkg::cnt_t LIM_64US = 16'(`LPB_LIM_64US_NS
        / `CLK_PERIOD_NS),
    parameter bus_timeout_pkg::cnt_t LIM_256US = 16'(`LPB_LIM_256US_NS
        / `CLK_PERIOD_NS)
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic bus_timer_control_i,
    input wire bus_timeout_pkg::cnt_t pb_limit_i,
    input wire logic lpb_timer_en_i,
    input wire bus_timeout_pkg::lpb_sel_t lpb_limit_sel_i,
    input wire logic data_bus_busy_n_i,
    input wire logic transfer_ack_n_i,
    input wire logic transfer_error_ack_n_i,
    input wire logic transfer_retry_n_i,
    input wire logic to_lpb_i,
    input wire logic lpb_cycle_n_i,
    input wire logic lpb_ack_n_i,
    input wire logic lpb_err_n_i,
    input wire logic vme_bound_i,
    output logic transfer_error_ack_n_o,
    output logic transfer_error_ack_oe_o,
    output logic lpb_err_n_o,
    output logic lpb_err_oe_o
);
    import bus_timeout_pkg::*;

    logic pb_term;
    logic pb_expire;
    logic lpb_term;
    logic lpb_expire;
    logic lpb_inf;
    cnt_t lpb_limit;
    logic pb_en;
    logic lpb_en;
    logic pb_fire;
    logic lpb_fire;
    logic pb_hold_ff;
    logic lpb_hold_ff;
    logic nxt_pb_hold;
    logic nxt_lpb_hold;

    function automatic cnt_t sel_limit(input lpb_sel_t sel);
        case (sel)
            `LPB_SEL_8US: sel_limit = LIM_8US - `CNT_ONE;
            `LPB_SEL_64US: sel_limit = LIM_64US - `CNT_ONE;
            `LPB_SEL_256US: sel_limit = LIM_256US - `CNT_ONE;
            default: sel_limit = `CNT_ZERO;
        endcase
    endfunction : sel_limit

    function automatic logic low_any(input logic a_n, input logic b_n,
        input logic c_n);
        low_any = !a_n || !b_n || !c_n;
    endfunction : low_any

    function automatic logic nxt_hold(input logic hold, input logic fired,
        input logic idle);
        if (fired && !idle)
        begin
            nxt_hold = 1'b1;
        end
        else if (idle)
        begin
            nxt_hold = 1'b0;
        end
        else
        begin
            nxt_hold = hold;
        end
    endfunction : nxt_hold

    assign pb_term = low_any(transfer_ack_n_i, transfer_error_ack_n_i,
        transfer_retry_n_i);
    assign lpb_term = low_any(lpb_ack_n_i, lpb_err_n_i, 1'b1);
    assign lpb_limit = sel_limit(lpb_limit_sel_i);
    assign lpb_inf = (lpb_limit_sel_i == `LPB_SEL_INF);

    assign pb_en = bus_timer_control_i && !to_lpb_i && !pb_hold_ff;
    assign lpb_en = lpb_timer_en_i && !vme_bound_i && !lpb_hold_ff;
    // hold off until the tenure ends
    assign nxt_pb_hold = nxt_hold(pb_hold_ff, pb_expire, data_bus_busy_n_i);
    assign nxt_lpb_hold = nxt_hold(lpb_hold_ff, lpb_expire, lpb_cycle_n_i);
    // a late termination cancels the pulse
    assign pb_fire = pb_expire && !pb_term;
    assign lpb_fire = lpb_expire && !lpb_term;

    cycle_timer u_pb_timer
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(pb_en),
        .active_i(!data_bus_busy_n_i),
        .term_i(pb_term),
        .infinite_i(1'b0),
        .limit_i(pb_limit_i),
        .expire_o(pb_expire)
    );

    cycle_timer u_lpb_timer
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(lpb_en),
        .active_i(!lpb_cycle_n_i),
        .term_i(lpb_term),
        .infinite_i(lpb_inf),
        .limit_i(lpb_limit),
        .expire_o(lpb_expire)
    );

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pb_hold_ff <= 1'b0;
        end
        else
        begin
            pb_hold_ff <= nxt_pb_hold;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lpb_hold_ff <= 1'b0;
        end
        else
        begin
            lpb_hold_ff <= nxt_lpb_hold;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            transfer_error_ack_n_o <= 1'b1;
        end
        else
        begin
            transfer_error_ack_n_o <= !pb_fire;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            transfer_error_ack_oe_o <= 1'b0;
        end
        else
        begin
            transfer_error_ack_oe_o <= pb_fire;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lpb_err_n_o <= 1'b1;
        end
        else
        begin
            lpb_err_n_o <= !lpb_fire;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lpb_err_oe_o <= 1'b0;
        end
        else
        begin
            lpb_err_oe_o <= lpb_fire;
        end
    end
endmodule : bus_cycle_timeout_monitor

/* bus_timeout_regs.svh */
/*
 * constants for the bus cycle timeout monitor: limit encodings and times.
 * assumes a 100 MHz core clock; included by bare name.
 */
`ifndef BUS_TIMEOUT_REGS_SVH
`define BUS_TIMEOUT_REGS_SVH

`define CLK_PERIOD_NS 10
`define LPB_LIM_8US_NS 8000
`define LPB_LIM_64US_NS 64000
`define LPB_LIM_256US_NS 256000
`define LPB_SEL_8US 2'h0
`define LPB_SEL_64US 2'h1
`define LPB_SEL_256US 2'h2
`define LPB_SEL_INF 2'h3
`define CNT_W 16
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define PB_LIMIT_DEF 16'h0100

`endif

/* bus_timeout_pkg.sv */
/*
 * types shared by the timeout monitor files.
 * assumes bus_timeout_regs.svh is on the include path.
 */
`include "bus_timeout_regs.svh"

package bus_timeout_pkg;
    typedef logic [`CNT_W-1:0] cnt_t;
    typedef logic [1:0] lpb_sel_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_FIRE = 3'h4
    } tmr_state_t;
endpackage : bus_timeout_pkg

/* cycle_timer.sv */
/*
 * one cycle timer: counts while a cycle runs, fires a one-cycle expiry.
 * assumes enable/active/term are synchronous to core_clk_i.
 */
`timescale 1ns/1ps
`include "bus_timeout_regs.svh"

module cycle_timer
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic active_i,
    input wire logic term_i,
    input wire logic infinite_i,
    input wire bus_timeout_pkg::cnt_t limit_i,
    output logic expire_o
);
    import bus_timeout_pkg::*;

    tmr_state_t state_ff;
    tmr_state_t nxt_state;
    cnt_t count_ff;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (enable_i && active_i && !term_i)
                    nxt_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (term_i || !active_i || !enable_i)
                    nxt_state = ST_IDLE;
                else if (!infinite_i && count_ff >= limit_i)
                    nxt_state = ST_FIRE;
            end
            ST_FIRE:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            count_ff <= `CNT_ZERO;
        else if (nxt_state == ST_RUN)
            count_ff <= count_ff + `CNT_ONE;
        else
            count_ff <= `CNT_ZERO;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            expire_o <= 1'b0;
        else
            expire_o <= (nxt_state == ST_FIRE);
    end
endmodule : cycle_timer

/* bcm_properties.sv */
/* timeout monitor checker; assumes the bind at the foot. */
`timescale 1ns/1ps
module bcm_properties
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic bus_timer_control_i,
    input wire logic data_bus_busy_n_i,
    input wire logic transfer_ack_n_i,
    input wire logic transfer_error_ack_n_i,
    input wire logic transfer_retry_n_i,
    input wire logic lpb_ack_n_i,
    input wire logic lpb_err_n_i,
    input wire logic to_lpb_i,
    input wire bus_timeout_pkg::lpb_sel_t lpb_limit_sel_i,
    input wire logic vme_bound_i,
    input wire logic transfer_error_ack_n_o,
    input wire logic transfer_error_ack_oe_o,
    input wire logic lpb_err_n_o,
    input wire logic lpb_err_oe_o
);
    wire p = !transfer_error_ack_n_o;
    wire l = !lpb_err_n_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_po; transfer_error_ack_oe_o == p; endproperty
    a_po: assert property (p_po) else $error("pb oe");
    property p_pw; p |=> !p; endproperty
    a_pw: assert property (p_pw) else $error("pb width");
    property p_pe; p |-> $past(bus_timer_control_i, 3); endproperty
    a_pe: assert property (p_pe) else $error("pb off");
    property p_pb; p |-> !$past(data_bus_busy_n_i, 3); endproperty
    a_pb: assert property (p_pb) else $error("pb idle");
    property p_pl; p |-> !$past(to_lpb_i, 3); endproperty
    a_pl: assert property (p_pl) else $error("pb routed");
    property p_pt;
        p |-> $past(transfer_ack_n_i) && $past(transfer_error_ack_n_i)
            && $past(transfer_retry_n_i);
    endproperty
    a_pt: assert property (p_pt) else $error("pb term");
    property p_lw; l |=> !l; endproperty
    a_lw: assert property (p_lw) else $error("lpb width");
    property p_lt; l |-> $past(lpb_ack_n_i) && $past(lpb_err_n_i); endproperty
    a_lt: assert property (p_lt) else $error("lpb term");
    property p_lo; lpb_err_oe_o == l; endproperty
    a_lo: assert property (p_lo) else $error("lpb oe");
    property p_lv; l |-> !$past(vme_bound_i, 3); endproperty
    a_lv: assert property (p_lv) else $error("lpb vme");
    property p_li; l |-> $past(lpb_limit_sel_i, 3) != 2'h3; endproperty
    a_li: assert property (p_li) else $error("lpb inf");
    cover property (p);
    cover property (l);
    cover property ($rose(data_bus_busy_n_i) && !p);
endmodule : bcm_properties
bind bus_cycle_timeout_monitor bcm_properties chk_u (.*);

/* pbus_partner.sv */
/* processor bus partner: one tenure, one termination (none for kind_i 3); go_i one cycle. */
`timescale 1ns/1ps
module pbus_partner
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic [7:0] wait_i,
    input wire logic [1:0] kind_i,
    input wire logic tea_n_i,
    output logic busy_n_o,
    output logic [2:0] term_n_o
);
    logic [7:0] cnt_ff;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_ff <= 8'h00;
        else if (go_i)
            cnt_ff <= wait_i;
        else if (cnt_ff != 8'h00)
            cnt_ff <= tea_n_i ? cnt_ff - 8'h01 : 8'h00;
    end
    assign busy_n_o = cnt_ff == 8'h00;
    assign term_n_o = cnt_ff == 8'h01 ? ~(3'h1 << kind_i) : 3'h7;
endmodule : pbus_partner

/* bus_cycle_timeout_monitor_tb.sv */
/* bench with a processor bus partner; assumes the bound checker. */
`timescale 1ns/1ps
module bus_cycle_timeout_monitor_tb;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, bus_timer_control_i = 1'b0;
    logic to_lpb_i = 1'b0, lpb_timer_en_i = 1'b0, vme_bound_i = 1'b0;
    logic lpb_cycle_n_i = 1'b1, go = 1'b0, lpb_ack_n_i = 1'b1;
    logic lpb_err_n_i = 1'b1, data_bus_busy_n_i, transfer_ack_n_i;
    logic transfer_error_ack_n_i, transfer_retry_n_i, lpb_err_n_o;
    logic transfer_error_ack_n_o, transfer_error_ack_oe_o, lpb_err_oe_o;
    logic [15:0] pb_limit_i = 16'h000A;
    logic [7:0] wt = 8'h00;
    logic [1:0] lpb_limit_sel_i = 2'h0, kd = 2'h0;
    int fails = 0, samples_checked = 0, cyc = 0, n;
    logic ok;
    always #5 core_clk_i = ~core_clk_i;
    bus_cycle_timeout_monitor #(.LIM_8US(16'h0008), .LIM_64US(16'h0010),
        .LIM_256US(16'h0020)) dut_u (.*);
    pbus_partner partner_u (.core_clk_i, .rst_n_i, .go_i(go), .wait_i(wt),
        .kind_i(kd), .tea_n_i(transfer_error_ack_n_o),
        .busy_n_o(data_bus_busy_n_i), .term_n_o({transfer_retry_n_i,
        transfer_error_ack_n_i, transfer_ack_n_i}));
    task check(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %h %h", $time, got, exp);
        end
    endtask : check
    task end_of_test;
        $display("fails %0d checks %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // cycle ceiling counts as a mismatch
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            end_of_test();
        end
    end
    task run(input logic lp);
        n = 0;
        @(posedge core_clk_i);
        #1 go = 1'b0;
        while (n < 40 && (lp ? lpb_err_n_o : transfer_error_ack_n_o) !== 1'b0)
        begin
            @(posedge core_clk_i);
            #1 n++;
        end
    endtask : run
    task t_pb_fire;
        bus_timer_control_i = 1'b1;
        wt = 8'hFF;
        kd = 2'h3;
        go = 1'b1;
        run(1'b0);
        check(16'(n > 10 && n < 15), 16'h0001);
        check(16'(transfer_error_ack_oe_o), 16'h0001);
        @(posedge core_clk_i);
        #1 check(16'(transfer_error_ack_n_o), 16'h0001);
    endtask : t_pb_fire
    task t_pb_quiet;
        for (int k = 0; k < 5; k++)
        begin
            bus_timer_control_i = k != 3;
            to_lpb_i = k == 4;
            wt = k < 3 ? 8'h09 : 8'h1E;
            kd = 2'(k);
            go = 1'b1;
            run(1'b0);
            check(16'(n), 16'h0028);
        end
    endtask : t_pb_quiet
    task t_lpb;
        lpb_timer_en_i = 1'b1;
        to_lpb_i = 1'b0;
        for (int s = 0; s < 5; s++)
        begin
            @(posedge core_clk_i);
            #1 lpb_limit_sel_i = 2'(s);
            vme_bound_i = s == 4;
            lpb_cycle_n_i = 1'b0;
            run(1'b1);
            lpb_cycle_n_i = 1'b1;
            ok = s < 3 ? n >= 8 << s && n < (8 << s) + 5 : n == 40;
            check(16'(ok), 16'h0001);
            check(16'(lpb_err_oe_o), 16'(s < 3));
        end
    endtask : t_lpb
    task t_lpb_term;
        @(posedge core_clk_i);
        #1 lpb_limit_sel_i = 2'h0;
        vme_bound_i = 1'b0;
        lpb_cycle_n_i = 1'b0;
        for (int j = 0; j < 2; j++)
        begin
            repeat (4) @(posedge core_clk_i);
            #1 lpb_ack_n_i = j != 0;
            lpb_err_n_i = j == 0;
            @(posedge core_clk_i);
            #1 lpb_ack_n_i = 1'b1;
            lpb_err_n_i = 1'b1;
            check(16'(lpb_err_n_o), 16'h0001);
        end
        run(1'b1);
        lpb_cycle_n_i = 1'b1;
        check(16'(n >= 8 && n < 13), 16'h0001);
    endtask : t_lpb_term
    task t_reset;
        bus_timer_control_i = 1'b1;
        wt = 8'hFF;
        kd = 2'h3;
        go = 1'b1;
        @(posedge core_clk_i);
        #1 go = 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1 rst_n_i = 1'b0;
        #1 check(16'(transfer_error_ack_n_o), 16'h0001);
        check(16'(transfer_error_ack_oe_o), 16'h0000);
        @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        wt = 8'h09;
        kd = 2'h0;
        go = 1'b1;
        run(1'b0);
        check(16'(n), 16'h0028);
    endtask : t_reset
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        t_pb_fire();
        t_pb_quiet();
        t_lpb();
        t_lpb_term();
        t_reset();
        end_of_test();
    end
endmodule : bus_cycle_timeout_monitor_tb
